// >>> hdl/skip_xor_exec.sv
// Execution logic for test-and-skip, xor-immediate and table write tail.
// Assumes instructions arrive with instr_valid in phase Q1 of a cycle and
// that the fetch unit reports whether the prefetched word is two words.
//
// Notes on behaviour
// - Zero operand on test-and-skip discards the prefetched instruction.
// - Test-and-skip takes one cycle, two when skipping a one-word follower.
// - Skipping a two-word follower makes three cycles in total.
// - Each inserted cycle does nothing in all four phases.
// - Bank bit zero takes the operand from the access bank.
// - Bank bit one uses the bank select register for the operand bank.
// - Extended set, bank bit zero, address up to 95: indexed offset.
// - Xor-immediate writes result to accumulator, sets N and Z, one cycle.
// - Table write puts the latch into the holding register pointer selects.
// - Pointer bit zero selects low byte when clear, high when set.
`timescale 1ns/10ps
`default_nettype none
module skip_xor_exec (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic                      instr_valid,
	input  wire logic [15:0]               instr_word,
	input  wire logic                      next_two_word,
	input  wire logic                      ext_set_en,
	input  wire logic [3:0]                bank_select_reg,
	input  wire logic [7:0]                file_rd_data,
	input  wire logic [7:0]                table_latch_reg,
	input  wire logic [2:0]                hold_rd_addr,
	output exec_pkg::operand_addr_type     operand,
	output logic      [1:0]                q_phase,
	output logic                           busy,
	output logic                           nop_cycle,
	output logic                           discard_fetch,
	output logic      [7:0]                accumulator,
	output exec_pkg::flags_type            flags,
	output logic      [20:0]               table_pointer_reg,
	output logic                           byte_high,
	output logic      [7:0]                hold_rd_data
);
	typedef enum logic [1:0] {IDLE, EXEC, NOP1, NOP2} state_type;

	state_type   state_reg;
	state_type   state_next;
	logic [15:0] ir_reg;
	logic        two_reg;
	logic        is_tst;
	logic        is_xor;
	logic        is_tbl;
	logic        skip_now;
	logic        hold_we;

	function automatic exec_pkg::operand_addr_type decode_addr(
		input logic       abit,
		input logic [7:0] f,
		input logic [3:0] bank_sel,
		input logic       ext);
		exec_pkg::operand_addr_type r;
		r.indexed = 1'b0;
		if (abit) begin
			r.addr = {bank_sel, f};
		end else if (ext && f <= exec_pkg::ACCESS_LIMIT) begin
			r.indexed = 1'b1;
			r.addr    = {4'h0, f};
		end else if (f < exec_pkg::ACCESS_SPLIT) begin
			r.addr = {4'h0, f};
		end else begin
			r.addr = {exec_pkg::BANK_ACCESS_HI, f};
		end
		return r;
	endfunction

	// Opcode decode of the latched instruction
	assign is_tst = (ir_reg[15:9] == exec_pkg::TSTSKIP_OP);
	assign is_xor = (ir_reg[15:8] == exec_pkg::XORIMM_OP);
	assign is_tbl = (ir_reg[15:2] == exec_pkg::TBLWR_OP);
	assign operand = decode_addr(ir_reg[8], ir_reg[7:0], bank_select_reg,
		ext_set_en);
	assign skip_now = (state_reg == EXEC) && is_tst &&
		(q_phase == exec_pkg::Q_LAST) && (file_rd_data == 8'h00);
	assign busy = (state_reg != IDLE);
	assign nop_cycle = (state_reg == NOP1) || (state_reg == NOP2);
	assign discard_fetch = skip_now;
	assign byte_high = table_pointer_reg[0];

	// Four-phase counter; stays at Q1 while idle so instructions align
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q_phase <= 2'h0;
		end else if (busy || instr_valid) begin
			q_phase <= q_phase + 2'h1;
		end
	end

	// Instruction capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ir_reg  <= 16'h0000;
			two_reg <= 1'b0;
		end else if (state_reg == IDLE && instr_valid) begin
			ir_reg <= instr_word;
		end else if (state_reg == EXEC && q_phase == exec_pkg::Q_LAST) begin
			two_reg <= next_two_word;
		end
	end

	// Cycle sequencing: skip inserts one or two dead cycles
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			IDLE: begin
				if (instr_valid) begin
					state_next = EXEC;
				end
			end
			EXEC: begin
				if (q_phase == exec_pkg::Q_LAST) begin
					state_next = skip_now ? NOP1 : IDLE;
				end
			end
			NOP1: begin
				if (q_phase == exec_pkg::Q_LAST) begin
					state_next = two_reg ? NOP2 : IDLE;
				end
			end
			NOP2: begin
				if (q_phase == exec_pkg::Q_LAST) begin
					state_next = IDLE;
				end
			end
			default: state_next = IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Accumulator and flags; only xor-immediate writes them here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accumulator <= exec_pkg::ACC_RESET;
			flags       <= '0;
		end else if (state_reg == EXEC && is_xor &&
			q_phase == exec_pkg::Q_WRITE) begin
			accumulator <= accumulator ^ ir_reg[7:0];
			flags.neg   <= accumulator[7] ^ ir_reg[7];
			flags.zero  <= ((accumulator ^ ir_reg[7:0]) == 8'h00);
		end
	end

	// Table write tail: store latch and adjust the pointer on the same edge
	assign hold_we = (state_reg == EXEC) && is_tbl &&
		(q_phase == exec_pkg::Q_WRITE);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			table_pointer_reg <= exec_pkg::PTR_RESET;
		end else if (hold_we) begin
			case (ir_reg[1:0])
				exec_pkg::TBL_POSTINC, exec_pkg::TBL_PREINC:
					table_pointer_reg <= table_pointer_reg + 21'h1;
				exec_pkg::TBL_POSTDEC:
					table_pointer_reg <= table_pointer_reg - 21'h1;
				default: table_pointer_reg <= table_pointer_reg;
			endcase
		end
	end

	// Pre-increment writes into the slot after the old pointer
	holding_mem u_hold (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wr_en   (hold_we),
		.wr_addr ((ir_reg[1:0] == exec_pkg::TBL_PREINC) ?
			3'(table_pointer_reg[2:0] + 3'h1) : table_pointer_reg[2:0]),
		.wr_data (table_latch_reg),
		.rd_addr (hold_rd_addr),
		.rd_data (hold_rd_data)
	);

	chk_skip_discard: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		skip_now |=> state_reg == NOP1) else $error("skip lost");
	chk_noskip_one: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(state_reg == EXEC && q_phase == 2'h3 && !skip_now) |=>
		state_reg == IDLE) else $error("no-skip long");
	chk_two_word: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(state_reg == NOP1 && q_phase == 2'h3 && two_reg) |=>
		state_reg == NOP2 [*4] ##1 state_reg == IDLE)
		else $error("two-word skip length");
	chk_nop_idle: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		nop_cycle |=> $stable(accumulator) && $stable(table_pointer_reg))
		else $error("nop changed state");
	chk_bank_sel: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		ir_reg[8] |-> operand.addr[11:8] == bank_select_reg && !operand.indexed)
		else $error("bank select");
	chk_access_bank: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(!ir_reg[8] && !ext_set_en && ir_reg[7:0] < 8'h60) |->
		operand.addr[11:8] == 4'h0) else $error("access low");
	chk_indexed: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(!ir_reg[8] && ext_set_en) |->
		operand.indexed == (ir_reg[7:0] <= 8'h5F))
		else $error("indexed mode");
	chk_xor_result: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(state_reg == EXEC && is_xor && q_phase == 2'h3) |=>
		accumulator == ($past(accumulator) ^ ir_reg[7:0]) &&
		flags.zero == (accumulator == 8'h00) && flags.neg == accumulator[7])
		else $error("xor result");
	chk_tst_flags: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(busy && is_tst) |=> $stable(flags))
		else $error("flags touched");
	chk_tbl_ptr: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(hold_we && ir_reg[1:0] == 2'h1) |=>
		table_pointer_reg == $past(table_pointer_reg) + 21'h1)
		else $error("pointer step");
	// Any single pointer step must swap between low and high byte
	chk_byte_sel: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(hold_we && ir_reg[1:0] != exec_pkg::TBL_NOCHANGE) |=>
		byte_high != $past(byte_high)) else $error("byte select");
endmodule
`default_nettype wire

// >>> hdl/exec_pkg.sv
// Shared constants and carrier types for the small execution block.
// Assumes a single core clock; the Q phase counter lives in the block.
`default_nettype none
package exec_pkg;
	// Opcode patterns (upper bits of the 16-bit instruction word)
	localparam logic [6:0]  TSTSKIP_OP    = 7'h33;   // 0110 011a
	localparam logic [7:0]  XORIMM_OP     = 8'h0A;   // 0000 1010
	localparam logic [13:0] TBLWR_OP      = 14'h0003; // 0000 0000 0000 11nn
	localparam logic [7:0]  ACCESS_LIMIT  = 8'h5F;   // Indexed offset limit
	localparam logic [3:0]  BANK_ACCESS_HI = 4'hF;   // Upper access half
	localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
	localparam int          HOLD_COUNT    = 8;
	localparam int          PTR_WIDTH     = 21;
	localparam logic [1:0]  Q_LAST        = 2'h3;
	localparam logic [1:0]  Q_READ        = 2'h1;
	localparam logic [1:0]  Q_WRITE       = 2'h3;
	localparam logic [7:0]  ACC_RESET     = 8'h00;
	localparam logic [20:0] PTR_RESET     = 21'h000000;
	localparam logic [1:0]  TBL_NOCHANGE  = 2'h0;
	localparam logic [1:0]  TBL_POSTINC   = 2'h1;
	localparam logic [1:0]  TBL_POSTDEC   = 2'h2;
	localparam logic [1:0]  TBL_PREINC    = 2'h3;

	// Operand address as presented to the register file
	typedef struct packed {
		logic       indexed;  // Indexed literal offset mode
		logic [11:0] addr;    // Full 12-bit file address
	} operand_addr_type;

	typedef struct packed {
		logic neg;
		logic zero;
	} flags_type;
endpackage
`default_nettype wire

// >>> hdl/holding_mem.sv
// Eight-byte table write holding memory with registered read data.
// Assumes one writer; read port reflects content one clock later.
`timescale 1ns/10ps
`default_nettype none
module holding_mem (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [2:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem_reg [exec_pkg::HOLD_COUNT];

	// Storage; erased flash pattern after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < exec_pkg::HOLD_COUNT; i++) begin
				mem_reg[i] <= 8'hFF;
			end
		end else if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	// Registered read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem_reg[rd_addr];
		end
	end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the skip, xor-immediate and table write block.
// Assumes one 125 MHz clock; the bench drives every port directly.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
	miscompares++; $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	logic                       clk_sys = 1'b0;
	logic                       rst_n = 1'b0;
	logic                       instr_valid = 1'b0;
	logic [15:0]                instr_word = 16'h0000;
	logic                       next_two_word = 1'b0;
	logic                       ext_set_en = 1'b0;
	logic [3:0]                 bank_select_reg = 4'h0;
	logic [7:0]                 file_rd_data = 8'h00;
	logic [7:0]                 table_latch_reg = 8'h00;
	logic [2:0]                 hold_rd_addr = 3'h0;
	exec_pkg::operand_addr_type operand;
	exec_pkg::operand_addr_type got_op;
	exec_pkg::flags_type        flags;
	logic [1:0]                 q_phase;
	logic                       busy;
	logic                       nop_cycle;
	logic                       discard_fetch;
	logic [7:0]                 accumulator;
	logic [20:0]                table_pointer_reg;
	logic                       byte_high;
	logic [7:0]                 hold_rd_data;
	int                         miscompares = 0;
	int                         total_checks = 0;
	int                         cycles = 0;
	int                         n_busy;
	int                         n_nop;
	int                         n_disc;

	skip_xor_exec skip_xor_exec_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.instr_valid(instr_valid), .instr_word(instr_word),
		.next_two_word(next_two_word), .ext_set_en(ext_set_en),
		.bank_select_reg(bank_select_reg), .file_rd_data(file_rd_data),
		.table_latch_reg(table_latch_reg), .hold_rd_addr(hold_rd_addr),
		.operand(operand), .q_phase(q_phase), .busy(busy),
		.nop_cycle(nop_cycle), .discard_fetch(discard_fetch),
		.accumulator(accumulator), .flags(flags),
		.table_pointer_reg(table_pointer_reg), .byte_high(byte_high),
		.hold_rd_data(hold_rd_data));

	// Half period of 4 ns
	always #4 clk_sys = ~clk_sys;

	// Hang guard: whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One instruction, then count busy, dead and discard cycles
	task automatic run(input logic [15:0] w, input logic two);
		@(posedge clk_sys); #1;
		instr_word = w;
		instr_valid = 1'b1;
		next_two_word = two;
		@(posedge clk_sys); #1;
		instr_valid = 1'b0;
		// Decode clock at Q1, before busy rises, belongs to the cycle
		n_busy = 1;
		n_nop = 0;
		n_disc = 0;
		got_op = operand;
		while (busy === 1'b1 && n_busy < 20) begin
			n_busy++;
			n_nop += (nop_cycle === 1'b1);
			n_disc += (discard_fetch === 1'b1);
			@(posedge clk_sys); #1;
		end
	endtask

	// Known example values, then a zero result and a negative result
	task automatic test_xor();
		run({exec_pkg::XORIMM_OP, 8'hB5}, 1'b0);
		run({exec_pkg::XORIMM_OP, 8'hAF}, 1'b0);
		`CHECK("acc", 8'h1A, accumulator)
		`CHECK("flags", 2'h0, flags)
		`CHECK("busy", 4, n_busy)
		`CHECK("phase", 2'h0, q_phase)
		run({exec_pkg::XORIMM_OP, 8'h1A}, 1'b0);
		`CHECK("flags", 2'h1, flags)
		run({exec_pkg::XORIMM_OP, 8'h80}, 1'b0);
		`CHECK("acc", 8'h80, accumulator)
		`CHECK("flags", 2'h2, flags)
		$display("test xor done");
	endtask

	// Skip not taken, taken one-word, taken two-word
	task automatic test_skip();
		file_rd_data = 8'h01;
		run({exec_pkg::TSTSKIP_OP, 1'b0, 8'h10}, 1'b1);
		`CHECK("busy", 4, n_busy)
		`CHECK("discard", 0, n_disc)
		file_rd_data = 8'h00;
		run({exec_pkg::TSTSKIP_OP, 1'b0, 8'h10}, 1'b0);
		`CHECK("busy", 8, n_busy)
		`CHECK("discard", 1, n_disc)
		`CHECK("nop", 4, n_nop)
		run({exec_pkg::TSTSKIP_OP, 1'b1, 8'h10}, 1'b1);
		`CHECK("busy", 12, n_busy)
		`CHECK("nop", 8, n_nop)
		`CHECK("acc", 8'h80, accumulator)
		`CHECK("flags", 2'h2, flags)
		$display("test skip done");
	endtask

	// Access bank both halves, bank select, indexed offset limit
	task automatic test_addr();
		file_rd_data = 8'h07;
		bank_select_reg = 4'h3;
		run({exec_pkg::TSTSKIP_OP, 1'b0, 8'h80}, 1'b0);
		`CHECK("op", 13'h0F80, got_op)
		run({exec_pkg::TSTSKIP_OP, 1'b0, 8'h20}, 1'b0);
		`CHECK("op", 13'h0020, got_op)
		run({exec_pkg::TSTSKIP_OP, 1'b1, 8'h20}, 1'b0);
		`CHECK("op", 13'h0320, got_op)
		ext_set_en = 1'b1;
		run({exec_pkg::TSTSKIP_OP, 1'b0, 8'h5F}, 1'b0);
		`CHECK("idx", 1'b1, got_op.indexed)
		run({exec_pkg::TSTSKIP_OP, 1'b0, 8'h60}, 1'b0);
		`CHECK("op", 13'h0F60, got_op)
		run({exec_pkg::TSTSKIP_OP, 1'b1, 8'h10}, 1'b0);
		`CHECK("idx", 1'b0, got_op.indexed)
		ext_set_en = 1'b0;
		$display("test addr done");
	endtask

	// Post-increment then pre-increment into the holding slots
	task automatic test_table();
		table_latch_reg = 8'h55;
		run({exec_pkg::TBLWR_OP, exec_pkg::TBL_POSTINC}, 1'b0);
		`CHECK("ptr", 21'h000001, table_pointer_reg)
		`CHECK("high", 1'b1, byte_high)
		table_latch_reg = 8'h34;
		run({exec_pkg::TBLWR_OP, exec_pkg::TBL_PREINC}, 1'b0);
		`CHECK("ptr", 21'h000002, table_pointer_reg)
		`CHECK("high", 1'b0, byte_high)
		hold_rd_addr = 3'h0;
		repeat (2) @(posedge clk_sys); #1;
		`CHECK("slot0", 8'h55, hold_rd_data)
		hold_rd_addr = 3'h1;
		repeat (2) @(posedge clk_sys); #1;
		`CHECK("slot1", 8'hFF, hold_rd_data)
		hold_rd_addr = 3'h2;
		repeat (2) @(posedge clk_sys); #1;
		`CHECK("slot2", 8'h34, hold_rd_data)
		// Post-decrement writes the old slot, no-change leaves the pointer
		table_latch_reg = 8'hA5;
		run({exec_pkg::TBLWR_OP, exec_pkg::TBL_POSTDEC}, 1'b0);
		`CHECK("ptr", 21'h000001, table_pointer_reg)
		table_latch_reg = 8'h3C;
		run({exec_pkg::TBLWR_OP, exec_pkg::TBL_NOCHANGE}, 1'b0);
		`CHECK("ptr", 21'h000001, table_pointer_reg)
		`CHECK("high", 1'b1, byte_high)
		hold_rd_addr = 3'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHECK("slot1", 8'h3C, hold_rd_data)
		hold_rd_addr = 3'h2;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHECK("slot2", 8'hA5, hold_rd_data)
		$display("test table done");
	endtask

	// Reset for 12 cycles, then each test in turn
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		test_xor();
		test_skip();
		test_addr();
		test_table();
		report_and_stop();
	end
endmodule
`default_nettype wire
